// ==== rtl/waveform_pkg.sv ====
package waveform_pkg;

    // ==========================================================
    // Register indices (byte address is index, data is 16 bits)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_COUNT = 4'h1;
    localparam logic [3:0] REG_CMP_A = 4'h2;
    localparam logic [3:0] REG_CMP_B = 4'h3;
    localparam logic [3:0] REG_CAPT = 4'h4;
    localparam logic [3:0] REG_FLAGS = 4'h5;
    localparam logic [3:0] REG_FORCE = 4'h6;
    localparam logic [3:0] REG_STATE = 4'h7;

    // ==========================================================
    // Flag bit positions in REG_FLAGS
    localparam int FLAG_OVF = 0;
    localparam int FLAG_CMP_A = 1;
    localparam int FLAG_CMP_B = 2;
    localparam int FLAG_CAPT = 3;
    localparam int NUM_FLAGS = 4;
    localparam int NUM_CH = 2;

    // ==========================================================
    // Waveform mode codes
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_CTC_CMP = 4'h4;
    localparam logic [3:0] MODE_FAST_8 = 4'h5;
    localparam logic [3:0] MODE_FAST_9 = 4'h6;
    localparam logic [3:0] MODE_FAST_10 = 4'h7;
    localparam logic [3:0] MODE_CTC_CAPT = 4'hC;
    localparam logic [3:0] MODE_FAST_CAPT = 4'hE;
    localparam logic [3:0] MODE_FAST_CMP = 4'hF;

    // ==========================================================
    // Counter values
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // ==========================================================
    // Compare output mode encodings
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    typedef struct packed {
        logic [3:0] waveformModeSelect;
        logic [1:0] compareOutputModeB;
        logic [1:0] compareOutputModeA;
    } ctrl_s;

    typedef struct packed {
        logic [NUM_CH-1:0] direction;
        logic [NUM_CH-1:0] value;
    } port_s;

endpackage

// ==== rtl/compare_channel.sv ====
`timescale 1ns/1ps
module compare_channel (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Timing
    input wire logic tick,
    input wire logic [15:0] counterValue,
    input wire logic matchBlocked,
    input wire logic topEvent,
    input wire logic pwmMode,
    // Software side
    input wire logic writeCompare,
    input wire logic [15:0] writeData,
    input wire logic forceStrobe,
    input wire logic [1:0] compareOutputMode,
    // Results
    output logic [15:0] bufferValue,
    output logic matchEvent,
    output logic waveformOutputState
);
    import waveform_pkg::*;

    logic [15:0] activeCmp_r;
    logic [15:0] bufCmp_r;
    logic state_r;
    logic nonPwmNxt;

    assign bufferValue = bufCmp_r;
    assign matchEvent = tick && !matchBlocked && (counterValue == activeCmp_r);

    always_comb begin
        unique case (compareOutputMode)
            COM_TOGGLE: nonPwmNxt = ~state_r;
            COM_CLEAR: nonPwmNxt = 1'b0;
            COM_SET: nonPwmNxt = 1'b1;
            default: nonPwmNxt = state_r;
        endcase
    end

    // ==========================================================
    // Compare register and its buffer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bufCmp_r <= CNT_BOTTOM;
        end else if (ce && writeCompare) begin
            bufCmp_r <= writeData;
        end
    end

    // Direct in non-PWM modes; reloaded from the buffer at top otherwise
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            activeCmp_r <= CNT_BOTTOM;
        end else if (ce) begin
            if (writeCompare && !pwmMode) begin
                activeCmp_r <= writeData;
            end else if (pwmMode && topEvent) begin
                activeCmp_r <= bufCmp_r;
            end
        end
    end

    // ==========================================================
    // Output state; mode bits are read live so a change acts at the next match
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= 1'b0;
        end else if (ce) begin
            if (forceStrobe && !pwmMode) begin
                state_r <= nonPwmNxt;
            end else if (matchEvent && !pwmMode) begin
                state_r <= nonPwmNxt;
            end else if (matchEvent && pwmMode) begin
                // Match wins over top, so compare equal to top gives a steady level in clear and set modes
                unique case (compareOutputMode)
                    COM_TOGGLE: state_r <= ~state_r;
                    COM_CLEAR: state_r <= 1'b1;
                    COM_SET: state_r <= 1'b0;
                    default: state_r <= state_r;
                endcase
            end else if (topEvent && pwmMode) begin
                if (compareOutputMode == COM_CLEAR) begin
                    state_r <= 1'b0;
                end else if (compareOutputMode == COM_SET) begin
                    state_r <= 1'b1;
                end
            end
        end
    end

    assign waveformOutputState = state_r;

    a_match_toggle: assert property (@(posedge clk) disable iff (!rst_n)
        ce && matchEvent && !pwmMode && !forceStrobe && compareOutputMode == COM_TOGGLE
        |=> state_r != $past(state_r))
        else $error("Toggle mode did not toggle on match");

endmodule // compare_channel

// ==== rtl/pin_override.sv ====
`timescale 1ns/1ps
module pin_override (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Sources
    input wire logic [1:0] compareOutputMode,
    input wire logic portValue,
    input wire logic outputPinDirectionBit,
    input wire logic waveformOutputState,
    // Pin
    output logic pinOut,
    output logic pinOe
);
    import waveform_pkg::*;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pinOut <= 1'b0;
            pinOe <= 1'b0;
        end else if (ce) begin
            pinOe <= outputPinDirectionBit;
            pinOut <= (compareOutputMode != COM_OFF) ? waveformOutputState : portValue;
        end
    end

    a_pin_input: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !outputPinDirectionBit |=> !pinOe)
        else $error("Pin driven while direction selects input");

endmodule // pin_override

// ==== rtl/waveform_generator.sv ====
`timescale 1ns/1ps
module waveform_generator (
    // Clock, reset and freeze
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Timer clock enable from the prescaler
    input wire logic tick,
    // Capture event from the input capture unit
    input wire logic captureEvent,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [15:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [15:0] rdData,
    // Port pin sources
    input wire waveform_pkg::port_s portCtl,
    // Pins
    output logic [1:0] pinOut,
    output logic [1:0] pinOe,
    output logic [1:0] waveformOutputState
);
    import waveform_pkg::*;

    // ==========================================================
    // Control and data registers
    ctrl_s ctrl_r;
    logic [15:0] counterValue_r;
    logic [15:0] captureValue_r;
    logic [NUM_FLAGS-1:0] flags_r;
    logic [NUM_FLAGS-1:0] flagSet;
    logic blockNext_r;
    logic [15:0] rdData_r;

    logic wrCtrl;
    logic wrCount;
    logic wrCapt;
    logic wrFlags;
    logic wrForce;
    logic [1:0] wrCmp;
    logic [1:0] forceBits;
    logic [1:0] com [NUM_CH];
    logic [15:0] cmpBuf [NUM_CH];
    logic [1:0] matchEvt;

    logic isFast;
    logic isCtc;
    logic topFromCmpA;
    logic topFromCapt;
    logic [15:0] topValue;
    logic topEvent;
    logic wrapEvent;
    logic advance;

    assign advance = ce && tick;
    assign wrCtrl = ce && wrStrobe && addr == REG_CTRL;
    assign wrCount = ce && wrStrobe && addr == REG_COUNT;
    assign wrCmp[0] = ce && wrStrobe && addr == REG_CMP_A;
    assign wrCmp[1] = ce && wrStrobe && addr == REG_CMP_B;
    assign wrCapt = ce && wrStrobe && addr == REG_CAPT;
    assign wrFlags = ce && wrStrobe && addr == REG_FLAGS;
    assign wrForce = ce && wrStrobe && addr == REG_FORCE;
    assign forceBits = wrForce ? wrData[1:0] : 2'h0;
    assign com[0] = ctrl_r.compareOutputModeA;
    assign com[1] = ctrl_r.compareOutputModeB;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r <= ctrl_s'(CTRL_RESET[$bits(ctrl_s)-1:0]);
        end else if (wrCtrl) begin
            ctrl_r <= ctrl_s'(wrData[$bits(ctrl_s)-1:0]);
        end
    end

    // ==========================================================
    // Mode decode
    always_comb begin
        isFast = 1'b0;
        isCtc = 1'b0;
        topFromCmpA = 1'b0;
        topFromCapt = 1'b0;
        topValue = CNT_MAX;
        unique case (ctrl_r.waveformModeSelect)
            MODE_CTC_CMP: begin
                isCtc = 1'b1;
                topFromCmpA = 1'b1;
                topValue = cmpBuf[0];
            end
            MODE_CTC_CAPT: begin
                isCtc = 1'b1;
                topFromCapt = 1'b1;
                topValue = captureValue_r;
            end
            MODE_FAST_8: begin
                isFast = 1'b1;
                topValue = TOP_8BIT;
            end
            MODE_FAST_9: begin
                isFast = 1'b1;
                topValue = TOP_9BIT;
            end
            MODE_FAST_10: begin
                isFast = 1'b1;
                topValue = TOP_10BIT;
            end
            MODE_FAST_CAPT: begin
                isFast = 1'b1;
                topFromCapt = 1'b1;
                topValue = captureValue_r;
            end
            MODE_FAST_CMP: begin
                isFast = 1'b1;
                topFromCmpA = 1'b1;
                topValue = cmpBuf[0];
            end
            // Normal and the dual-slope codes that this block leaves out
            default: begin
                isFast = 1'b0;
            end
        endcase
    end

    // A blocked cycle also hides the top match, so the counter runs on past it
    assign topEvent = advance && (isFast || isCtc) && !blockNext_r
        && counterValue_r == topValue;
    assign wrapEvent = advance && !isFast && counterValue_r == CNT_MAX;

    // ==========================================================
    // Counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            counterValue_r <= CNT_BOTTOM;
        end else if (wrCount) begin
            counterValue_r <= wrData;
        end else if (topEvent) begin
            counterValue_r <= CNT_BOTTOM;
        end else if (advance) begin
            counterValue_r <= counterValue_r + CNT_ONE;
        end
    end

    // A counter write masks the next timer clock's matches, even when stopped
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            blockNext_r <= 1'b0;
        end else if (wrCount) begin
            blockNext_r <= 1'b1;
        end else if (advance) begin
            blockNext_r <= 1'b0;
        end
    end

    // ==========================================================
    // Compare channels and pin overrides
    // Compare A's buffer doubles as the direct register outside PWM modes
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            compare_channel u_cmp (
                .clk(clk),
                .rst_n(rst_n),
                .ce(ce),
                .tick(advance),
                .counterValue(counterValue_r),
                .matchBlocked(blockNext_r),
                .topEvent(topEvent && isFast),
                .pwmMode(isFast),
                .writeCompare(wrCmp[ch]),
                .writeData(wrData),
                .forceStrobe(forceBits[ch]),
                .compareOutputMode(com[ch]),
                .bufferValue(cmpBuf[ch]),
                .matchEvent(matchEvt[ch]),
                .waveformOutputState(waveformOutputState[ch])
            );
            pin_override u_pin (
                .clk(clk),
                .rst_n(rst_n),
                .ce(ce),
                .compareOutputMode(com[ch]),
                .portValue(portCtl.value[ch]),
                .outputPinDirectionBit(portCtl.direction[ch]),
                .waveformOutputState(waveformOutputState[ch]),
                .pinOut(pinOut[ch]),
                .pinOe(pinOe[ch])
            );
        end
    endgenerate

    // ==========================================================
    // Capture register; compare output mode plays no part here
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            captureValue_r <= CNT_BOTTOM;
        end else if (wrCapt) begin
            captureValue_r <= wrData;
        end else if (ce && captureEvent && !topFromCapt) begin
            captureValue_r <= counterValue_r;
        end
    end

    // ==========================================================
    // Flags: hardware set beats a write-one clear in the same cycle
    always_comb begin
        flagSet = '0;
        flagSet[FLAG_OVF] = (isFast ? topEvent : wrapEvent);
        flagSet[FLAG_CMP_A] = matchEvt[0] || (topEvent && topFromCmpA);
        flagSet[FLAG_CMP_B] = matchEvt[1];
        flagSet[FLAG_CAPT] = (ce && captureEvent && !topFromCapt)
            || (topEvent && topFromCapt);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_r <= '0;
        end else if (ce) begin
            flags_r <= (flags_r & ~(wrFlags ? wrData[NUM_FLAGS-1:0] : '0)) | flagSet;
        end
    end

    // ==========================================================
    // Read port: data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdData_r <= CNT_BOTTOM;
        end else if (ce && rdStrobe) begin
            unique case (addr)
                REG_CTRL: rdData_r <= {8'h00, ctrl_r};
                REG_COUNT: rdData_r <= counterValue_r;
                REG_CMP_A: rdData_r <= cmpBuf[0];
                REG_CMP_B: rdData_r <= cmpBuf[1];
                REG_CAPT: rdData_r <= captureValue_r;
                REG_FLAGS: rdData_r <= {12'h000, flags_r};
                REG_STATE: rdData_r <= {14'h0, waveformOutputState};
                default: rdData_r <= CNT_BOTTOM;
            endcase
        end else if (ce) begin
            rdData_r <= CNT_BOTTOM;
        end
    end

    assign rdData = rdData_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_reset_state: assert property ($past(!rst_n) |-> waveformOutputState == 2'h0)
        else $error("Waveform state not cleared by reset");

    a_normal_wrap: assert property (
        ctrl_r.waveformModeSelect == MODE_NORMAL && advance && !wrCount
        && counterValue_r == CNT_MAX |=> counterValue_r == CNT_BOTTOM)
        else $error("Normal mode did not wrap to zero");

    a_normal_ovf: assert property (
        ctrl_r.waveformModeSelect == MODE_NORMAL && advance && !wrCount
        && counterValue_r == CNT_MAX |=> flags_r[FLAG_OVF] && counterValue_r == CNT_BOTTOM)
        else $error("Overflow flag missing at wrap");

    a_count_write: assert property (wrCount |=> counterValue_r == $past(wrData))
        else $error("Counter write not accepted");

    a_ctc_clear: assert property (
        isCtc && topEvent && !wrCount |=> counterValue_r == CNT_BOTTOM)
        else $error("Clear-on-match did not clear counter");

    a_ctc_flag: assert property (
        isCtc && topEvent && topFromCmpA |=> flags_r[FLAG_CMP_A])
        else $error("Top did not set compare A flag");

    a_fast_top: assert property (
        isFast && topEvent |=> flags_r[FLAG_OVF] && counterValue_r == CNT_BOTTOM)
        else $error("Fast PWM top handling wrong");

    a_match_block: assert property (
        blockNext_r && advance |-> matchEvt == 2'h0 && !topEvent)
        else $error("Match not blocked after counter write");

    a_freeze: assert property (!ce |=> $stable(counterValue_r) && $stable(flags_r))
        else $error("State moved while clock enable low");

    a_match_flag: assert property (matchEvt[1] && ce |=> flags_r[FLAG_CMP_B])
        else $error("Compare B flag not set after match");

    a_ctc_ovf: assert property (
        isCtc && advance && !wrCount && counterValue_r == CNT_MAX
        |=> flags_r[FLAG_OVF] && counterValue_r == CNT_BOTTOM)
        else $error("Clear-on-match overflow flag missing at wrap");

    a_capture_load: assert property (
        ce && captureEvent && !topFromCapt && !wrCapt
        |=> captureValue_r == $past(counterValue_r) && flags_r[FLAG_CAPT])
        else $error("Capture did not load counter or set flag");

    a_fast_cmp_flag: assert property (
        isFast && matchEvt[0] |=> flags_r[FLAG_CMP_A])
        else $error("Fast PWM match did not set compare A flag");

    a_capt_top_flag: assert property (
        topEvent && topFromCapt |=> flags_r[FLAG_CAPT])
        else $error("Top from capture did not set capture flag");

    // Below top the count must step by one, never skip or clear early
    a_fast_count: assert property (
        isFast && advance && !wrCount && counterValue_r < topValue
        |=> counterValue_r == $past(counterValue_r) + CNT_ONE)
        else $error("Fast PWM counter did not step up");

    a_force_set: assert property (
        wrForce && wrData[0] && !isFast && com[0] == COM_SET
        |=> waveformOutputState[0])
        else $error("Forced set did not reach output A state");

    // The pin lags the state by one register stage
    a_pin_follow: assert property (
        ce && com[0] != COM_OFF |=> pinOut[0] == $past(waveformOutputState[0]))
        else $error("Pin A not overridden by waveform state");

endmodule // waveform_generator

// ==== verification/port_pin_model.sv ====
`timescale 1ns/1ps
module port_pin_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Requested port setup
    input wire logic [1:0] dirReq,
    input wire logic [1:0] valReq,
    // Port register outputs
    output waveform_pkg::port_s portCtl
);
    import waveform_pkg::*;

    // ==========================================================
    // Port registers
    // Cleared on reset, so both pins come up as inputs driving low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            portCtl <= '0;
        end else begin
            portCtl.direction <= dirReq;
            portCtl.value <= valReq;
        end
    end
endmodule // port_pin_model

// ==== verification/test_waveform_generator.sv ====
`timescale 1ns/1ps
module test_waveform_generator;
    import waveform_pkg::*;

    // ==========================================================
    // Signals
    typedef struct packed {
        logic [3:0] mode;
        logic [15:0] start;
        logic [3:0] n;
        logic [15:0] exp;
        logic ovf;
    } step_s;
    typedef struct packed {
        logic [3:0] mode;
        logic [15:0] top;
        logic [1:0] flagBit;
        logic [7:0] toggles;
        logic ovf;
    } ctc_s;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic tick = 1'b0;
    logic captureEvent = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wrData = 16'h0000;
    logic wrStrobe = 1'b0;
    logic rdStrobe = 1'b0;
    logic [15:0] rdData;
    logic [1:0] dirReq = 2'h0;
    logic [1:0] valReq = 2'h0;
    port_s portCtl;
    logic [1:0] pinOut;
    logic [1:0] pinOe;
    logic [1:0] waveformOutputState;
    logic [1:0] prevState;
    logic [15:0] got;
    int numErrors = 0;
    int nTests = 0;
    int cnt;
    int hiNon;
    logic [1:0] comSeq [4] = '{COM_SET, COM_CLEAR, COM_TOGGLE, COM_OFF};
    logic forceExp [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    step_s steps [9] = '{'{MODE_NORMAL, 16'hFFFD, 4'h3, 16'h0000, 1'b1},
        '{MODE_FAST_8, 16'h00FE, 4'h2, 16'h0000, 1'b1},
        '{MODE_FAST_9, 16'h01FE, 4'h2, 16'h0000, 1'b1},
        '{MODE_FAST_10, 16'h03FE, 4'h2, 16'h0000, 1'b1},
        '{MODE_FAST_8, 16'h00FF, 4'h1, 16'h0100, 1'b0},
        '{MODE_CTC_CMP, 16'h000A, 4'h5, 16'h000F, 1'b0},
        '{MODE_CTC_CAPT, 16'h000A, 4'h3, 16'h000D, 1'b0},
        '{MODE_FAST_CAPT, 16'h0002, 4'h2, 16'h0000, 1'b1},
        '{MODE_FAST_CMP, 16'h0002, 4'h2, 16'h0000, 1'b1}};
    ctc_s clear_on_match_mode [3] = '{'{MODE_CTC_CMP, 16'h0003, 2'h1, 8'h0A, 1'b0},
        '{MODE_CTC_CAPT, 16'h0001, 2'h3, 8'h14, 1'b0},
        '{MODE_CTC_CMP, 16'h0000, 2'h1, 8'h28, 1'b1}};

    initial begin
        forever #5 clk = ~clk;
    end

    port_pin_model u_port_pin_model (.clk(clk), .rst_n(rst_n), .dirReq(dirReq),
        .valReq(valReq), .portCtl(portCtl));

    waveform_generator u_waveform_generator (.clk(clk), .rst_n(rst_n), .ce(ce), .tick(tick),
        .captureEvent(captureEvent), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdData(rdData), .portCtl(portCtl), .pinOut(pinOut),
        .pinOe(pinOe), .waveformOutputState(waveformOutputState));

    // ==========================================================
    // Tasks
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        nTests++;
        if (seen !== exp) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1;
        d = rdData;
    endtask

    // Holds the timer clock enable high for exactly n system clocks
    task automatic ticks(input int n);
        @(posedge clk);
        tick <= 1'b1;
        repeat (n) @(posedge clk);
        tick <= 1'b0;
    endtask

    task automatic test_done;
        if (numErrors == 0 && nTests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================================
    // Watchdog
    initial begin
        repeat (5000) @(posedge clk);
        numErrors++;
        test_done();
    end

    // ==========================================================
    // Tests
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(REG_STATE, got);
        check("state", 16'h0000, got);
        check("pins", 16'h0000, {12'h000, pinOut, pinOe});
        rd(4'h8, got);
        check("unmapped", 16'h0000, got);
        for (int ch = 0; ch < 2; ch++) begin
            for (int i = 0; i < 4; i++) begin
                wr(REG_CTRL, 16'(comSeq[i]) << (2 * ch));
                wr(REG_FORCE, 16'(1 << ch));
                rd(REG_STATE, got);
                check("forced", 16'(forceExp[i]), 16'(got[ch]));
            end
        end
        // Both states are now high; only an override can show it on pin A
        @(posedge clk);
        dirReq <= 2'b01;
        wr(REG_CTRL, 16'h0003);
        repeat (3) @(posedge clk);
        #1;
        check("pinOut", 16'h0001, 16'(pinOut));
        check("pinOe", 16'h0001, 16'(pinOe));
        @(posedge clk);
        dirReq <= 2'b00;
        repeat (3) @(posedge clk);
        #1;
        check("pinOe", 16'h0000, 16'(pinOe));
        wr(REG_CMP_A, 16'h0003);
        wr(REG_CAPT, 16'h0003);
        foreach (steps[i]) begin
            wr(REG_CTRL, {8'h00, steps[i].mode, 4'h0});
            wr(REG_FLAGS, 16'h000F);
            wr(REG_COUNT, steps[i].start);
            ticks(int'(steps[i].n));
            rd(REG_COUNT, got);
            check("counter", steps[i].exp, got);
            rd(REG_FLAGS, got);
            check("overflow", 16'(steps[i].ovf), 16'(got[FLAG_OVF]));
        end
        wr(REG_CTRL, 16'h0000);
        wr(REG_CMP_B, 16'h0005);
        wr(REG_COUNT, 16'h0004);
        wr(REG_FLAGS, 16'h000F);
        ticks(1);
        rd(REG_FLAGS, got);
        check("flag early", 16'h0000, 16'(got[FLAG_CMP_B]));
        ticks(1);
        rd(REG_FLAGS, got);
        check("flag late", 16'h0001, 16'(got[FLAG_CMP_B]));
        foreach (clear_on_match_mode[i]) begin
            wr(REG_CTRL, {8'h00, clear_on_match_mode[i].mode, COM_OFF, COM_TOGGLE});
            wr(REG_CMP_A, clear_on_match_mode[i].top);
            wr(REG_CMP_B, clear_on_match_mode[i].top);
            wr(REG_CAPT, clear_on_match_mode[i].top);
            // One below top, so the blocked first tick hides no match
            wr(REG_COUNT, clear_on_match_mode[i].top - 16'h0001);
            wr(REG_FLAGS, 16'h000F);
            @(posedge clk);
            tick <= 1'b1;
            repeat (8) @(posedge clk);
            #1;
            prevState = waveformOutputState;
            cnt = 0;
            repeat (40) begin
                @(posedge clk);
                #1;
                if (waveformOutputState[0] !== prevState[0]) cnt++;
                prevState[0] = waveformOutputState[0];
            end
            check("toggles", 16'(clear_on_match_mode[i].toggles), 16'(cnt));
            check("idle channel", 16'(prevState[1]), 16'(waveformOutputState[1]));
            @(posedge clk);
            tick <= 1'b0;
            rd(REG_FLAGS, got);
            check("top flag", 16'h0001, 16'(got[clear_on_match_mode[i].flagBit]));
            check("overflow", 16'(clear_on_match_mode[i].ovf), 16'(got[FLAG_OVF]));
        end
        wr(REG_CMP_A, 16'h0007);
        wr(REG_CMP_B, 16'h0002);
        for (int k = 0; k < 2; k++) begin
            wr(REG_CTRL, {8'h00, MODE_FAST_CMP, (k == 1) ? COM_SET : COM_CLEAR, COM_OFF});
            wr(REG_FLAGS, 16'h000F);
            @(posedge clk);
            tick <= 1'b1;
            repeat (16) @(posedge clk);
            cnt = 0;
            repeat (64) begin
                @(posedge clk);
                #1;
                if (waveformOutputState[1] === 1'b1) cnt++;
            end
            @(posedge clk);
            tick <= 1'b0;
            if (k == 0) hiNon = cnt;
            rd(REG_FLAGS, got);
            check("pwm flags", 16'h0007, got);
        end
        check("complement", 16'h0040, 16'(hiNon + cnt));
        // Top 7 and compare 2: high for five of every eight ticks
        check("duty", 16'h0028, 16'(hiNon));
        for (int k = 0; k < 2; k++) begin
            wr(REG_CTRL, (k == 1) ? 16'h000F : 16'h0000);
            wr(REG_FLAGS, 16'h000F);
            wr(REG_COUNT, 16'h0120 + 16'(k));
            @(posedge clk);
            captureEvent <= 1'b1;
            @(posedge clk);
            captureEvent <= 1'b0;
            rd(REG_CAPT, got);
            check("capture", 16'h0120 + 16'(k), got);
            rd(REG_FLAGS, got);
            check("capture flag", 16'h0001, 16'(got[FLAG_CAPT]));
        end
        @(posedge clk);
        ce <= 1'b0;
        wr(REG_COUNT, 16'h0055);
        ticks(2);
        @(posedge clk);
        ce <= 1'b1;
        rd(REG_COUNT, got);
        check("frozen counter", 16'h0121, got);
        test_done();
    end
endmodule // test_waveform_generator
